/* File: design/lsd_pkg.sv */
// Constants shared by the segment LCD controller and driver.
package lsd_pkg;

    // Display RAM window in the CPU address space.
    localparam logic [15:0] RAM_FIRST = 16'hF740;
    localparam logic [15:0] RAM_LAST  = 16'hF74F;
    localparam int          RAM_BYTES = 16;

    // Duty select codes.
    localparam logic [1:0] DUTY_STATIC  = 2'h0;
    localparam logic [1:0] DUTY_HALF    = 2'h1;
    localparam logic [1:0] DUTY_THIRD   = 2'h2;
    localparam logic [1:0] DUTY_QUARTER = 2'h3;

    // Drive level codes on every common and segment output.
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_V3  = 2'h1;
    localparam logic [1:0] LVL_V2  = 2'h2;
    localparam logic [1:0] LVL_V1  = 2'h3;

    // Field positions inside the frame clock select code.
    localparam int CKS_SYS_BIT = 3;
    localparam int CKS_SUB4_BIT = 1;
    localparam int CKS_SUB2_BIT = 0;

    // Operating clock ticks in one eighth of a frame.
    localparam logic [5:0] SUB_HALF_TICKS = 6'h20;
    localparam logic [5:0] SYS_HALF_TICKS = 6'h3F;

    // Last eighth of a frame; 1/3 duty uses only six eighths.
    localparam logic [2:0] LAST_HALF       = 3'h7;
    localparam logic [2:0] LAST_HALF_THIRD = 3'h5;

    // Charge pulse codes.
    localparam logic [3:0] CDS_FIXED_HIGH = 4'h0;
    localparam logic [3:0] CDS_FIXED_LOW  = 4'h7;
    localparam int         CDS_WIDE_BIT   = 3;
    localparam int         CDS_32_BIT     = 2;

    // Segments enabled per step of the segment select code.
    localparam logic [5:0] SEGS_PER_STEP = 6'h04;

endpackage : lsd_pkg

/* File: design/lsd_charge_pulse.sv */
// Charge and discharge pulse generator for the bias ladder.
`timescale 1ns/1ps
`default_nettype none
module lsd_charge_pulse (
    // Clock, reset and enables.
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic       opTick,
    // Charge duty code.
    input  wire logic [3:0] chargeDutySelect,
    // Ladder connect, high while the ladder is tied in.
    output logic            ladderConnect
);

    logic [4:0] phaseCnt;   // Position inside the 32-tick period.
    logic       connectNext; // Connect level for the current position.

    // Period counter advances on every operating clock tick.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phaseCnt <= 5'h00;
        end else if (ce) begin
            if (!run) begin
                phaseCnt <= 5'h00;
            end else if (opTick) begin
                phaseCnt <= phaseCnt + 5'h01;
            end
        end
    end

    // Compare the position against the selected fraction.
    always_comb begin
        connectNext = 1'b0;
        if (chargeDutySelect[lsd_pkg::CDS_WIDE_BIT]) begin
            if (chargeDutySelect[lsd_pkg::CDS_32_BIT]) begin
                connectNext = (phaseCnt == 5'h00);
            end else begin
                connectNext = (phaseCnt[4:1] == 4'h0);
            end
        end else if (chargeDutySelect == lsd_pkg::CDS_FIXED_HIGH) begin
            connectNext = 1'b1;
        end else if (chargeDutySelect == lsd_pkg::CDS_FIXED_LOW) begin
            connectNext = 1'b0;
        end else begin
            connectNext = ({1'b0, phaseCnt[4:2]} < chargeDutySelect);
        end
    end

    // Registered so the ladder switch never sees a decode glitch.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ladderConnect <= 1'b0;
        end else if (ce) begin
            ladderConnect <= run & connectNext;
        end
    end

endmodule // lsd_charge_pulse
`default_nettype wire

/* File: design/lsd_lcd_driver.sv */
// Segment LCD controller: display RAM, frame timing and drive levels.
`timescale 1ns/1ps
`default_nettype none
module lsd_lcd_driver (
    // Clock, reset and clock enable.
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    // Subclock pin, asynchronous to clk.
    input  wire logic        subClkIn,
    // Display controls.
    input  wire logic        displayActive,
    input  wire logic        displayDataGate,
    input  wire logic [1:0]  dutySelect,
    input  wire logic [3:0]  segmentSelect,
    input  wire logic [3:0]  frameClockSelect,
    input  wire logic        waveformTypeSelect,
    input  wire logic        commonDriveBoost,
    input  wire logic [3:0]  chargeDutySelect,
    // CPU memory port for the display RAM.
    input  wire logic [15:0] cpuAddr,
    input  wire logic [15:0] cpuWdata,
    input  wire logic        cpuWrite,
    input  wire logic        cpuRead,
    input  wire logic        cpuWord,
    output logic [15:0]      cpuRdata,
    output logic             cpuAck,
    // Panel drive levels, two bits per pin.
    output logic [7:0]       commonLevel,
    output logic [63:0]      segmentLevel,
    output logic             ladderConnect,
    output logic             frameStart
);

    logic [7:0]  ram [lsd_pkg::RAM_BYTES]; // One bit per common/segment.
    logic [1:0]  subSync;      // Two-stage synchroniser for the subclock.
    logic        subPrev;      // Previous synchronised subclock level.
    logic [1:0]  subDiv;       // Subclock divider for /2 and /4.
    logic [7:0]  presc;        // System clock prescaler.
    logic        opTick;       // One operating clock tick.
    logic [5:0]  halfCnt;      // Ticks inside the current eighth.
    logic [2:0]  halfIdx;      // Eighth of the frame.
    logic        frameParity;  // Toggles per frame, drives B waveform.
    logic        frameEnd;     // Last tick of the frame.
    logic [1:0]  dutyAct;      // Frame-aligned copies of the settings.
    logic [3:0]  cksAct;
    logic        abAct;
    logic        boostAct;
    logic [1:0]  curCom;       // Common being scanned.
    logic        mPhase;       // Polarity of the drive.
    logic [7:0]  comNext;
    logic [63:0] segNext;
    logic [3:0]  ramIdx;       // Byte addressed by the CPU.
    logic        ramHit;

    // Which RAM bit holds a given segment and common for a duty.
    function automatic logic [6:0] segRamBit(input logic [1:0] duty,
                                             input logic [4:0] seg,
                                             input logic [1:0] com);
        logic [6:0] idx;
        idx = 7'h00;
        case (duty)
            lsd_pkg::DUTY_STATIC: idx = {2'h0, seg};
            lsd_pkg::DUTY_HALF:   idx = {1'b0, seg, com[0]};
            default:              idx = {seg[4:1], seg[0], com};
        endcase
        return idx;
    endfunction

    // Common level for a selected or idle common at a polarity.
    function automatic logic [1:0] comLevelOf(input logic [1:0] duty,
                                              input logic sel,
                                              input logic m);
        logic [1:0] lvl;
        lvl = lsd_pkg::LVL_VSS;
        if (sel || duty == lsd_pkg::DUTY_STATIC) begin
            lvl = m ? lsd_pkg::LVL_VSS : lsd_pkg::LVL_V1;
        end else if (duty == lsd_pkg::DUTY_HALF) begin
            lvl = lsd_pkg::LVL_V2;
        end else begin
            lvl = m ? lsd_pkg::LVL_V2 : lsd_pkg::LVL_V3;
        end
        return lvl;
    endfunction

    // Segment level for lit or dark data at a polarity.
    function automatic logic [1:0] segLevelOf(input logic [1:0] duty,
                                              input logic on,
                                              input logic m);
        logic [1:0] lvl;
        lvl = lsd_pkg::LVL_VSS;
        if (on) begin
            lvl = m ? lsd_pkg::LVL_V1 : lsd_pkg::LVL_VSS;
        end else if (duty == lsd_pkg::DUTY_STATIC ||
                     duty == lsd_pkg::DUTY_HALF) begin
            lvl = m ? lsd_pkg::LVL_VSS : lsd_pkg::LVL_V1;
        end else begin
            lvl = m ? lsd_pkg::LVL_V3 : lsd_pkg::LVL_V2;
        end
        return lvl;
    endfunction

    assign ramHit = (cpuAddr >= lsd_pkg::RAM_FIRST) &&
                    (cpuAddr <= lsd_pkg::RAM_LAST);
    assign ramIdx = cpuAddr[3:0];

    // CPU writes; a word goes to an even pair, high byte first.
    always_ff @(posedge clk) begin
        if (ce && cpuWrite && ramHit) begin
            if (cpuWord) begin
                ram[{ramIdx[3:1], 1'b0}] <= cpuWdata[15:8];
                ram[{ramIdx[3:1], 1'b1}] <= cpuWdata[7:0];
            end else begin
                ram[ramIdx] <= cpuWdata[7:0];
            end
        end
    end

    // CPU reads answer one cycle later; outside the window reads zero.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cpuRdata <= 16'h0000;
            cpuAck   <= 1'b0;
        end else if (ce) begin
            cpuAck <= cpuRead | cpuWrite;
            if (cpuRead && ramHit && cpuWord) begin
                cpuRdata <= {ram[{ramIdx[3:1], 1'b0}],
                             ram[{ramIdx[3:1], 1'b1}]};
            end else if (cpuRead && ramHit) begin
                cpuRdata <= {8'h00, ram[ramIdx]};
            end else if (cpuRead) begin
                cpuRdata <= 16'h0000;
            end
        end
    end

    // Subclock pin passes two flops before the edge detector reads it.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            subSync <= 2'h0;
            subPrev <= 1'b0;
            subDiv  <= 2'h0;
        end else if (ce) begin
            subSync <= {subSync[0], subClkIn};
            subPrev <= subSync[1];
            if (subSync[1] && !subPrev) begin
                subDiv <= subDiv + 2'h1;
            end
        end
    end

    // Free-running prescaler for the system clock divisions.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            presc <= 8'h00;
        end else if (ce) begin
            presc <= presc + 8'h01;
        end
    end

    // Operating clock tick selected by the frame clock code.
    always_comb begin
        logic       subEdge;
        logic [7:0] mask;
        subEdge = subSync[1] & ~subPrev;
        mask    = 8'h00;
        opTick  = 1'b0;
        if (cksAct[lsd_pkg::CKS_SYS_BIT]) begin
            case (cksAct[2:0])
                3'h0:    mask = 8'h01;
                3'h1:    mask = 8'h03;
                3'h2:    mask = 8'h07;
                3'h3:    mask = 8'h0F;
                3'h4:    mask = 8'h1F;
                3'h5:    mask = 8'h3F;
                3'h6:    mask = 8'h7F;
                default: mask = 8'hFF;
            endcase
            opTick = ((presc & mask) == mask);
        end else if (cksAct[lsd_pkg::CKS_SUB4_BIT]) begin
            opTick = subEdge && (subDiv == 2'h3);
        end else if (cksAct[lsd_pkg::CKS_SUB2_BIT]) begin
            opTick = subEdge && subDiv[0];
        end else begin
            opTick = subEdge;
        end
    end

    assign frameEnd = opTick &&
        (halfCnt == ((cksAct[lsd_pkg::CKS_SYS_BIT] ?
                      lsd_pkg::SYS_HALF_TICKS :
                      lsd_pkg::SUB_HALF_TICKS) - 6'h01)) &&
        (halfIdx == ((dutyAct == lsd_pkg::DUTY_THIRD) ?
                     lsd_pkg::LAST_HALF_THIRD : lsd_pkg::LAST_HALF));

    // Frame timing runs on its own once active, with no CPU action.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            halfCnt     <= 6'h00;
            halfIdx     <= 3'h0;
            frameParity <= 1'b0;
        end else if (ce) begin
            if (!displayActive) begin
                halfCnt     <= 6'h00;
                halfIdx     <= 3'h0;
                frameParity <= 1'b0;
            end else if (frameEnd) begin
                halfCnt     <= 6'h00;
                halfIdx     <= 3'h0;
                frameParity <= ~frameParity;
            end else if (opTick) begin
                if (halfCnt == ((cksAct[lsd_pkg::CKS_SYS_BIT] ?
                                 lsd_pkg::SYS_HALF_TICKS :
                                 lsd_pkg::SUB_HALF_TICKS) - 6'h01)) begin
                    halfCnt <= 6'h00;
                    halfIdx <= halfIdx + 3'h1;
                end else begin
                    halfCnt <= halfCnt + 6'h01;
                end
            end
        end
    end

    // Settings are taken only between frames, so no frame is cut short.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            dutyAct  <= lsd_pkg::DUTY_STATIC;
            cksAct   <= 4'h0;
            abAct    <= 1'b0;
            boostAct <= 1'b0;
        end else if (ce && (frameEnd || !displayActive)) begin
            dutyAct  <= dutySelect;
            cksAct   <= frameClockSelect;
            abAct    <= waveformTypeSelect;
            boostAct <= commonDriveBoost;
        end
    end

    // Scan position and drive polarity.
    always_comb begin
        case (dutyAct)
            lsd_pkg::DUTY_STATIC: curCom = 2'h0;
            lsd_pkg::DUTY_HALF:   curCom = {1'b0, halfIdx[2]};
            default:              curCom = halfIdx[2:1];
        endcase
        mPhase = abAct ? frameParity : halfIdx[0];
    end

    // Logical common waveforms, then routed onto the four pins.
    always_comb begin
        logic [1:0] lv [4];
        for (int c = 0; c < 4; c++) begin
            lv[c] = comLevelOf(dutyAct, curCom == c[1:0], mPhase);
        end
        comNext = {4{lsd_pkg::LVL_VSS}};
        comNext[1:0] = lv[0];
        case (dutyAct)
            lsd_pkg::DUTY_STATIC: begin
                if (boostAct) begin
                    comNext = {4{lv[0]}};
                end
            end
            lsd_pkg::DUTY_HALF: begin
                comNext[3:2] = boostAct ? lv[0] : lv[1];
                comNext[7:6] = boostAct ? lv[1] : lsd_pkg::LVL_VSS;
            end
            lsd_pkg::DUTY_THIRD: begin
                comNext[5:0] = {lv[2], lv[1], lv[0]};
            end
            default: begin
                comNext = {lv[3], lv[2], lv[1], lv[0]};
            end
        endcase
        if (!displayActive) begin
            comNext = {4{lsd_pkg::LVL_VSS}};
        end
    end

    // Per-segment data fetch and level, one instance per segment pin.
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : gSeg
            logic [6:0] bitIdx;
            logic       lit;
            logic       enabled;
            assign bitIdx  = segRamBit(dutyAct, 5'(g), curCom);
            assign lit     = displayDataGate &
                             ram[bitIdx[6:3]][bitIdx[2:0]];
            assign enabled = (6'(g) < ({2'h0, segmentSelect} *
                              lsd_pkg::SEGS_PER_STEP));
            assign segNext[2*g +: 2] =
                (enabled && displayActive) ?
                segLevelOf(dutyAct, lit, mPhase) :
                lsd_pkg::LVL_VSS;
        end
    endgenerate

    // Output registers for the panel pins.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            commonLevel  <= 8'h00;
            segmentLevel <= 64'h0000000000000000;
            frameStart   <= 1'b0;
        end else if (ce) begin
            commonLevel  <= comNext;
            segmentLevel <= segNext;
            frameStart   <= frameEnd & displayActive;
        end
    end

    // Bias ladder pulse generator.
    lsd_charge_pulse uCharge (
        .clk              (clk),
        .rst_b            (rst_b),
        .ce               (ce),
        .run              (displayActive),
        .opTick           (opTick),
        .chargeDutySelect (chargeDutySelect),
        .ladderConnect    (ladderConnect)
    );

endmodule // lsd_lcd_driver
`default_nettype wire

/* File: tb/lsd_panel_model.sv */
// Passive glass model that records which cells saw full drive.
`timescale 1ns/1ps
`default_nettype none
module lsd_panel_model (
    // Clock and clear of the record.
    input  wire logic         clk,
    input  wire logic         clearLit,
    // Drive levels from the controller.
    input  wire logic [7:0]   commonLevel,
    input  wire logic [63:0]  segmentLevel,
    // One bit per cell, index 32 times common plus segment.
    output logic     [127:0]  litSeen
);
    // A cell lights only on the full V1 to VSS swing.
    // Partial swings are ignored, as a real cell stays dark there.
    always_ff @(posedge clk) begin
        for (int c = 0; c < 4; c++) begin
            for (int s = 0; s < 32; s++) begin
                if (clearLit) begin
                    litSeen[32*c+s] <= 1'b0;
                end else if ({commonLevel[2*c+:2], segmentLevel[2*s+:2]}
                             == {lsd_pkg::LVL_V1, lsd_pkg::LVL_VSS} ||
                             {commonLevel[2*c+:2], segmentLevel[2*s+:2]}
                             == {lsd_pkg::LVL_VSS, lsd_pkg::LVL_V1}) begin
                    litSeen[32*c+s] <= 1'b1;
                end
            end
        end
    end
endmodule // lsd_panel_model
`default_nettype wire

/* File: tb/lsd_lcd_driver_monitor.sv */
// Port checker for the segment LCD controller.
`timescale 1ns/1ps
`default_nettype none
module lsd_monitor (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        rst_b,
    // Controls.
    input wire logic        ce,
    input wire logic        displayActive,
    input wire logic [1:0]  dutySelect,
    input wire logic        commonDriveBoost,
    // CPU port.
    input wire logic [15:0] cpuAddr,
    input wire logic        cpuWrite,
    input wire logic        cpuRead,
    input wire logic [15:0] cpuRdata,
    input wire logic        cpuAck,
    // Panel side.
    input wire logic [7:0]  commonLevel,
    input wire logic [63:0] segmentLevel,
    input wire logic        ladderConnect,
    input wire logic        frameStart
);
    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    logic [15:0] gapReg;   // Cycles since the last frame start.
    logic        primedReg; // A frame start has been seen.
    // Frame gap counter; cleared when the display halts.
    always_ff @(posedge clk) begin
        if (!rst_b || !displayActive) begin
            gapReg    <= 16'h0000;
            primedReg <= 1'b0;
        end else if (frameStart) begin
            gapReg    <= 16'h0001;
            primedReg <= 1'b1;
        end else if (gapReg != 16'hFFFF) begin
            gapReg <= gapReg + 16'h0001;
        end
    end
    a_ack_follows: assert property (
        ce && (cpuRead || cpuWrite) |=> cpuAck)
        else $error("request not acknowledged");
    a_ack_cause: assert property (
        cpuAck |-> $past(ce && (cpuRead || cpuWrite)))
        else $error("acknowledge without request");
    a_unmapped_zero: assert property (
        ce && cpuRead && (cpuAddr < lsd_pkg::RAM_FIRST ||
        cpuAddr > lsd_pkg::RAM_LAST) |=> cpuRdata == 16'h0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !(ce && cpuRead) |=> $stable(cpuRdata))
        else $error("read data moved without read");
    a_halt_quiet: assert property (
        !displayActive |=> commonLevel == 8'h00 &&
        segmentLevel == 64'h0 && !ladderConnect)
        else $error("outputs driven while halted");
    a_frame_pulse: assert property (
        frameStart |=> !frameStart)
        else $error("frame start wider than one cycle");
    a_frame_length: assert property (
        frameStart && primedReg |-> gapReg >= 16'h02F4)
        else $error("frame shorter than six eighths");
    a_static_boost: assert property (
        frameStart && commonDriveBoost && $past(commonDriveBoost) &&
        dutySelect == lsd_pkg::DUTY_STATIC &&
        $past(dutySelect) == lsd_pkg::DUTY_STATIC |-> ##2
        (commonLevel == {4{commonLevel[1:0]}}) [*8])
        else $error("static boost commons differ");
    a_half_boost: assert property (
        frameStart && commonDriveBoost && $past(commonDriveBoost) &&
        dutySelect == lsd_pkg::DUTY_HALF &&
        $past(dutySelect) == lsd_pkg::DUTY_HALF |-> ##2
        (commonLevel[3:2] == commonLevel[1:0]) [*8])
        else $error("half boost second pin differs");
endmodule // lsd_monitor
bind lsd_lcd_driver lsd_monitor lsd_monitor_i (
    .clk(clk), .rst_b(rst_b), .ce(ce), .displayActive(displayActive),
    .dutySelect(dutySelect), .commonDriveBoost(commonDriveBoost),
    .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
    .cpuRdata(cpuRdata), .cpuAck(cpuAck), .commonLevel(commonLevel),
    .segmentLevel(segmentLevel), .ladderConnect(ladderConnect),
    .frameStart(frameStart));
`default_nettype wire

/* File: tb/lsd_lcd_driver_bench.sv */
// Self-checking bench for the segment LCD controller.
`timescale 1ns/1ps
`default_nettype none
module lsd_lcd_driver_bench;
    logic         clk, rst_b = 1'b0, displayActive = 1'b0, clearLit = 1'b0;
    logic         displayDataGate = 1'b0, waveformTypeSelect = 1'b0;
    logic         commonDriveBoost = 1'b0, cpuWrite = 1'b0, cpuRead = 1'b0;
    logic         cpuWord = 1'b0, cpuAck, ladderConnect, frameStart;
    logic [1:0]   dutySelect = 2'h0, prevLvl;
    logic [3:0]   segmentSelect = 4'h8, frameClockSelect = 4'h8;
    logic [3:0]   chargeDutySelect = 4'h0, subCnt = 4'h0;
    logic [15:0]  cpuAddr = 16'h0000, cpuWdata = 16'h0000, cpuRdata, rd;
    logic [7:0]   commonLevel;
    logic [63:0]  segmentLevel;
    logic [55:0]  idleSegs;
    logic [127:0] litSeen;
    int           errTotal = 0, checksDone = 0, n, hi, moves;
    logic [3:0]   tCks [4] = '{4'h8, 4'h9, 4'h8, 4'h0};
    logic [1:0]   tDuty [4] = '{2'h0, 2'h3, 2'h2, 2'h1};
    int           tGap [4] = '{1008, 2016, 756, 4096};
    logic [3:0]   cdCode [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5,
                                  4'h6, 4'h7, 4'h8, 4'hB, 4'hC, 4'hF};
    int           cdHigh [12] = '{640, 80, 160, 240, 320, 400, 480, 0,
                                  40, 40, 20, 20};
    lsd_lcd_driver lsd_lcd_driver_i (
        .clk(clk), .rst_b(rst_b), .ce(1'b1), .subClkIn(subCnt[3]),
        .displayActive(displayActive), .displayDataGate(displayDataGate),
        .dutySelect(dutySelect), .segmentSelect(segmentSelect),
        .frameClockSelect(frameClockSelect),
        .waveformTypeSelect(waveformTypeSelect),
        .commonDriveBoost(commonDriveBoost),
        .chargeDutySelect(chargeDutySelect), .cpuAddr(cpuAddr),
        .cpuWdata(cpuWdata), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
        .cpuWord(cpuWord), .cpuRdata(cpuRdata), .cpuAck(cpuAck),
        .commonLevel(commonLevel), .segmentLevel(segmentLevel),
        .ladderConnect(ladderConnect), .frameStart(frameStart));
    lsd_panel_model lsd_panel_model_i (
        .clk(clk), .clearLit(clearLit), .commonLevel(commonLevel),
        .segmentLevel(segmentLevel), .litSeen(litSeen));
    // 40 MHz system clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Subclock with one rising edge every sixteen system clocks.
    always @(posedge clk) subCnt <= #1 subCnt + 4'h1;
    // Prints the totals and the verdict, then stops the run.
    task automatic conclude();
        $display("checks %0d mismatches %0d", checksDone, errTotal);
        if (errTotal == 0 && checksDone > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Compares one result with its expected value.
    task automatic chk(input logic [127:0] got, exp, input string what);
        checksDone++;
        if (got !== exp) begin
            errTotal++;
            $display("unexpected at %0t: %s %0h", $time, what, got);
        end
    endtask
    // Moves to just after the next rising edge.
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // One CPU access, acknowledged one cycle after it is taken.
    task automatic cpu(input logic wr, wd, input logic [15:0] a, d);
        cpuWrite = wr;
        cpuRead = !wr;
        cpuWord = wd;
        cpuAddr = a;
        cpuWdata = d;
        tick();
        cpuWrite = 1'b0;
        cpuRead = 1'b0;
        rd = cpuRdata;
        chk(128'(cpuAck), 128'h1, "ack");
        tick();
    endtask
    // Waits for a frame start; n plus one is the cycles waited.
    task automatic waitFrame();
        n = 0;
        tick();
        while (frameStart !== 1'b1 && n < 20000) begin
            tick();
            n++;
        end
        if (n >= 20000) begin
            chk(128'h0, 128'h1, "frame timeout");
            conclude();
        end
    endtask
    // Applies settings and lets two frame ends pass.
    task automatic cfg(input logic [1:0] d, input logic [3:0] s, k,
                       input logic ab, bo, gt);
        dutySelect = d;
        segmentSelect = s;
        frameClockSelect = k;
        waveformTypeSelect = ab;
        commonDriveBoost = bo;
        displayDataGate = gt;
        waitFrame();
        waitFrame();
    endtask
    // Records one whole frame on the glass and compares the lit cells.
    task automatic litTest(input logic [1:0] d, input logic [3:0] s,
                           input logic bo, gt, input logic [127:0] m, e);
        cfg(d, s, 4'h8, 1'b0, bo, gt);
        clearLit = 1'b1;
        tick();
        clearLit = 1'b0;
        waitFrame();
        chk(litSeen & m, e, "lit cells");
    endtask
    initial begin
        repeat (20) tick();
        rst_b = 1'b1;
        cpu(1'b1, 1'b0, 16'hF740, 16'h005A);
        cpu(1'b0, 1'b0, 16'hF740, 16'h0000);
        chk(rd, 16'h005A, "byte read");
        cpu(1'b1, 1'b1, 16'hF742, 16'h1234);
        cpu(1'b0, 1'b0, 16'hF743, 16'h0000);
        chk(rd, 16'h0034, "odd byte");
        cpu(1'b0, 1'b1, 16'hF743, 16'h0000);
        chk(rd, 16'h1234, "word read");
        cpu(1'b1, 1'b0, 16'hF74F, 16'h00A5);
        cpu(1'b1, 1'b0, 16'hF750, 16'h00FF);
        cpu(1'b0, 1'b0, 16'hF74F, 16'h0000);
        chk(rd, 16'h00A5, "last byte");
        cpu(1'b0, 1'b0, 16'hF750, 16'h0000);
        chk(rd, 16'h0000, "unmapped read");
        $display("test ram done");
        displayActive = 1'b1;
        for (int i = 0; i < 4; i++) begin
            cfg(tDuty[i], 4'h8, tCks[i], 1'b0, 1'b0, 1'b1);
            waitFrame();
            chk(128'(n + 1), 128'(tGap[i]), "frame length");
        end
        $display("test frame timing done");
        for (int ab = 0; ab < 2; ab++) begin
            cfg(lsd_pkg::DUTY_STATIC, 4'h8, 4'h8, ab[0], 1'b0, 1'b1);
            prevLvl = commonLevel[1:0];
            moves = 0;
            repeat (1007) begin
                tick();
                if (commonLevel[1:0] !== prevLvl) moves++;
                prevLvl = commonLevel[1:0];
            end
            chk(128'(moves >= 6), 128'(ab == 0), "polarity moves");
        end
        $display("test waveform done");
        for (int k = 0; k < 8; k++) cpu(1'b1, 1'b1, 16'hF740 + 16'(2*k), 0);
        cpu(1'b1, 1'b0, 16'hF740, 16'h0021);
        cpu(1'b1, 1'b0, 16'hF74F, 16'h0080);
        litTest(2'h3, 4'h8, 1'b0, 1'b0, '1, 128'h0);
        litTest(2'h3, 4'h8, 1'b0, 1'b1, '1,
                128'h80000000_00000000_00000002_00000001);
        litTest(2'h2, 4'h8, 1'b0, 1'b1, 128'hFFFFFFFF_FFFFFFFF_FFFFFFFF,
                128'h2_00000001);
        litTest(2'h0, 4'h8, 1'b0, 1'b1, 128'hFFFFFFFF, 128'h21);
        litTest(2'h0, 4'h8, 1'b1, 1'b1, '1,
                128'h00000021_00000021_00000021_00000021);
        litTest(2'h1, 4'h8, 1'b0, 1'b1, 128'hFFFFFFFF_FFFFFFFF,
                128'h4_00000001);
        litTest(2'h1, 4'h8, 1'b1, 1'b1,
                128'hFFFFFFFF_00000000_FFFFFFFF_FFFFFFFF,
                128'h00000004_00000000_00000001_00000001);
        $display("test mapping done");
        for (int k = 0; k < 8; k++) cpu(1'b1, 1'b1, 16'hF740 + 16'(2*k), '1);
        litTest(2'h3, 4'h1, 1'b0, 1'b1, {4{32'h0000000F}},
                {4{32'h0000000F}});
        idleSegs = segmentLevel[63:8];
        moves = 0;
        repeat (1008) begin
            tick();
            if (segmentLevel[63:8] !== idleSegs) moves++;
        end
        chk(128'(moves), 128'h0, "disabled segments moved");
        $display("test segment select done");
        for (int i = 0; i < 12; i++) begin
            chargeDutySelect = cdCode[i];
            waitFrame();
            hi = 0;
            repeat (640) begin
                tick();
                if (ladderConnect === 1'b1) hi++;
            end
            chk(128'(hi), 128'(cdHigh[i]), "ladder high time");
        end
        $display("test charge pulse done");
        displayActive = 1'b0;
        repeat (2) tick();
        chk({commonLevel, segmentLevel, ladderConnect}, 0, "halt");
        $display("test halt done");
        conclude();
    end
endmodule // lsd_lcd_driver_bench
`default_nettype wire
